// File: hw/swb_defs.vh
`ifndef SWB_DEFS_VH
`define SWB_DEFS_VH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define SWB_CLK_PERIOD_NS 10
`define SWB_TICK_PERIOD_NS 1000
`define SWB_TICK_CYCLES ((`SWB_TICK_PERIOD_NS + `SWB_CLK_PERIOD_NS - 1) / `SWB_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Fixed internal times, in time base ticks (1 us each)
// ----------------------------------------------------------------
`define SWB_DOM_TIMEOUT_US 2000
`define SWB_DOM_TIMEOUT_TICKS (`SWB_DOM_TIMEOUT_US * 1000 / `SWB_TICK_PERIOD_NS)
`define SWB_FILTER_US 10
`define SWB_FILTER_TICKS (`SWB_FILTER_US * 1000 / `SWB_TICK_PERIOD_NS)

// ----------------------------------------------------------------
// Mode select encoding {high bit, low bit}
// ----------------------------------------------------------------
`define SWB_MSEL_SLEEP 2'h0
`define SWB_MSEL_HIGH_SPEED 2'h1
`define SWB_MSEL_WAKE_CALL 2'h2
`define SWB_MSEL_NORMAL 2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SWB_SYNC_RESET 1'b0
`define SWB_TX_CMD_RESET 1'b1

`endif

// File: hw/swb_sync.v
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Two flip-flop synchroniser for pin levels
// ----------------------------------------------------------------
module swb_sync #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: hw/swb_filt.v
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Glitch filter: output follows input once it held for N ticks
// ----------------------------------------------------------------
module swb_filt #(
  parameter TICKS = 10,
  parameter CW = 12
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire tick_in,
  input wire level_in,
  output wire level_out
);

  reg level_q;
  reg [CW-1:0] cnt_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      level_q <= 1'b0;
      cnt_q <= {CW{1'b0}};
    end else if (level_in == level_q) begin
      cnt_q <= {CW{1'b0}};
    end else if (tick_in) begin
      if (cnt_q >= TICKS[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
        level_q <= level_in;
        cnt_q <= {CW{1'b0}};
      end else begin
        cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign level_out = level_q;

endmodule

// File: hw/swb_ctrl.v
`timescale 1ns/10ps
`include "swb_defs.vh"

// Summary of operation
// [RL1] Mode pins: 00 sleep, 01 high speed, 10 wake-up call, 11 normal.
// [RL2] Sleep ends on a mode pin change or a filtered high-voltage bus wake.
// [RL3] Bus-woken with pins unchanged, return to sleep once the wake level goes.
// [RL4] Sleep keeps the load ground switch closed.
// [RL5] High speed mode turns slew shaping off, up to 100 Kbit/s.
// [RL6] Wake-up call mode drives dominant bits at the high wake-up voltage.
// [RL7] Normal mode drives dominant bits at normal voltage, typically 25 Kbit/s.
// [RL8] Normal and wake-up call edges are slew shaped, strength from program pin.
// [RL9] Transmit command is inverted: low asks dominant, high asks recessive.
// [RL10] Transmit low beyond the fixed timeout forces the bus recessive.
// [RL11] Transmit high clears the timeout at once and re-arms the driver.
// [RL12] Loss of ground opens the load-to-ground switch automatically.
// [RL13] In awake modes every bus level goes to the receive output.
// [RL14] In sleep only a wake-up level bus shows on the receive output.
// [RL15] Bus detection uses a fixed filter time against short disturbances.
// [RL16] Receive high for recessive bus, low for any dominant bus.
// [RL17] Mode pins have pull-downs, so undriven pins read low.
// [RL18] Receive output is open drain: pulls low or releases.
// [RL19] Transmit command has an external pull-up; undriven means recessive.
// [RL20] Timeout and filter times are parameters counted in time base ticks.
// [RL21] With mode pins undriven the device comes up in sleep.
module swb_ctrl #(
  parameter TICK_CYCLES = `SWB_TICK_CYCLES,
  parameter DOM_TIMEOUT_TICKS = `SWB_DOM_TIMEOUT_TICKS,
  parameter FILTER_TICKS = `SWB_FILTER_TICKS,
  parameter SLEW_W = 4
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire tx_cmd_n_in,
  input wire mode_select_low_bit_in,
  input wire mode_select_high_bit_in,
  input wire bus_line_io_in,
  input wire bus_wake_level_in,
  input wire ground_loss_in,
  input wire [SLEW_W-1:0] slew_program_in,
  output reg bus_line_io_out,
  output reg bus_line_io_oe_out,
  output reg bus_high_volt_out,
  output reg slew_enable_out,
  output reg [SLEW_W-1:0] slew_strength_out,
  output reg rx_data_out,
  output reg rx_data_oe_out,
  output reg load_switch_on_out,
  output reg dom_timeout_out,
  output reg awake_out
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam TW = 16;
  localparam DW = 16;

  localparam [4:0] ST_SLEEP = 5'h01;
  localparam [4:0] ST_BUS_WAKE = 5'h02;
  localparam [4:0] ST_HIGH_SPEED = 5'h04;
  localparam [4:0] ST_WAKE_CALL = 5'h08;
  localparam [4:0] ST_NORMAL = 5'h10;

  // ----------------------------------------------------------------
  // Decoding of the mode select pair into a state
  // ----------------------------------------------------------------
  function [4:0] swb_mode_state;
    input [1:0] msel;
    begin
      case (msel)
        `SWB_MSEL_SLEEP: swb_mode_state = ST_SLEEP; // RL1
        `SWB_MSEL_HIGH_SPEED: swb_mode_state = ST_HIGH_SPEED; // RL1
        `SWB_MSEL_WAKE_CALL: swb_mode_state = ST_WAKE_CALL; // RL1
        `SWB_MSEL_NORMAL: swb_mode_state = ST_NORMAL; // RL1
        default: swb_mode_state = ST_SLEEP;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire [1:0] msel_sync;
  wire tx_cmd_n_sync;
  wire bus_dom_sync;
  wire bus_wake_sync;
  wire gnd_loss_sync;

  // Mode pins reset low, matching the pull-downs
  swb_sync #(
    .WIDTH(2),
    .RESET_VAL({`SWB_SYNC_RESET, `SWB_SYNC_RESET})
  ) u_msel_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .async_in({mode_select_high_bit_in, mode_select_low_bit_in}),
    .sync_out(msel_sync)
  ); // RL17 RL21

  // Transmit command resets high, as if pulled up
  swb_sync #(
    .WIDTH(1),
    .RESET_VAL(`SWB_TX_CMD_RESET)
  ) u_tx_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .async_in(tx_cmd_n_in),
    .sync_out(tx_cmd_n_sync)
  ); // RL19

  swb_sync #(
    .WIDTH(3),
    .RESET_VAL({3{`SWB_SYNC_RESET}})
  ) u_bus_sync (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .async_in({ground_loss_in, bus_wake_level_in, bus_line_io_in}),
    .sync_out({gnd_loss_sync, bus_wake_sync, bus_dom_sync})
  );

  // ----------------------------------------------------------------
  // Internal time base
  // ----------------------------------------------------------------
  reg [TW-1:0] tick_cnt_q;
  reg tick_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt_q <= {TW{1'b0}};
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= TICK_CYCLES[TW-1:0] - {{(TW-1){1'b0}}, 1'b1}) begin
      tick_cnt_q <= {TW{1'b0}};
      tick_q <= 1'b1; // RL20
    end else begin
      tick_cnt_q <= tick_cnt_q + {{(TW-1){1'b0}}, 1'b1};
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus detection filters
  // ----------------------------------------------------------------
  wire bus_dom_filt;
  wire bus_wake_filt;

  swb_filt #(
    .TICKS(FILTER_TICKS),
    .CW(DW)
  ) u_dom_filt (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .tick_in(tick_q),
    .level_in(bus_dom_sync),
    .level_out(bus_dom_filt)
  ); // RL15

  swb_filt #(
    .TICKS(FILTER_TICKS),
    .CW(DW)
  ) u_wake_filt (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .tick_in(tick_q),
    .level_in(bus_wake_sync),
    .level_out(bus_wake_filt)
  ); // RL15

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  reg [4:0] state_q;
  reg [4:0] state_d;
  wire [4:0] pin_state;

  assign pin_state = swb_mode_state(msel_sync);

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SLEEP: begin
        if (pin_state != ST_SLEEP) begin
          state_d = pin_state; // RL2
        end else if (bus_wake_filt) begin
          state_d = ST_BUS_WAKE; // RL2
        end
      end
      ST_BUS_WAKE: begin
        if (pin_state != ST_SLEEP) begin
          state_d = pin_state; // RL2
        end else if (!bus_wake_filt) begin
          state_d = ST_SLEEP; // RL3
        end
      end
      ST_HIGH_SPEED, ST_WAKE_CALL, ST_NORMAL: begin
        state_d = pin_state; // RL1
      end
      default: begin
        state_d = ST_SLEEP;
      end
    endcase
  end

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_SLEEP; // RL21
    end else begin
      state_q <= state_d;
    end
  end

  wire tx_mode;
  wire slew_mode;

  assign tx_mode = state_q[2] | state_q[3] | state_q[4];
  assign slew_mode = state_q[3] | state_q[4]; // RL5 RL8

  // ----------------------------------------------------------------
  // Dominant timeout guard
  // ----------------------------------------------------------------
  reg [DW-1:0] dom_cnt_q;
  reg timed_out_q;

  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dom_cnt_q <= {DW{1'b0}};
      timed_out_q <= 1'b0;
    end else if (tx_cmd_n_sync) begin
      dom_cnt_q <= {DW{1'b0}}; // RL11
      timed_out_q <= 1'b0; // RL11
    end else if (tick_q && !timed_out_q) begin
      if (dom_cnt_q >= DOM_TIMEOUT_TICKS[DW-1:0] - {{(DW-1){1'b0}}, 1'b1}) begin
        timed_out_q <= 1'b1; // RL10
      end else begin
        dom_cnt_q <= dom_cnt_q + {{(DW-1){1'b0}}, 1'b1};
      end
    end
  end

  // Transmit low asks for dominant unless guarded
  wire drive_dom;

  assign drive_dom = tx_mode & ~tx_cmd_n_sync & ~timed_out_q; // RL9 RL10

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  wire rx_dominant;

  // Awake: any dominant level; sleep: only the wake level
  assign rx_dominant = state_q[0] ? bus_wake_filt : (bus_dom_filt | bus_wake_filt); // RL13 RL14

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bus_line_io_out <= 1'b0;
      bus_line_io_oe_out <= 1'b0;
      bus_high_volt_out <= 1'b0;
      slew_enable_out <= 1'b0;
      slew_strength_out <= {SLEW_W{1'b0}};
      rx_data_out <= 1'b0;
      rx_data_oe_out <= 1'b0;
      load_switch_on_out <= 1'b1;
      dom_timeout_out <= 1'b0;
      awake_out <= 1'b0;
    end else begin
      bus_line_io_out <= drive_dom; // RL9
      bus_line_io_oe_out <= drive_dom; // RL9
      bus_high_volt_out <= drive_dom & state_q[3]; // RL6 RL7
      slew_enable_out <= slew_mode; // RL5 RL8
      slew_strength_out <= slew_mode ? slew_program_in : {SLEW_W{1'b0}}; // RL8
      rx_data_out <= 1'b0; // RL18
      rx_data_oe_out <= rx_dominant; // RL16 RL18
      load_switch_on_out <= ~gnd_loss_sync; // RL4 RL12
      dom_timeout_out <= timed_out_q;
      awake_out <= ~state_q[0];
    end
  end

endmodule

// File: verif/swb_ctrl_sva.sv
`timescale 1ns/10ps
// ------
// Port checker
// ------
module swb_ctrl_chk #(
  parameter TICK_CYCLES = 2,
  parameter DOM_TIMEOUT_TICKS = 20,
  parameter SLEW_W = 4
) (
  input wire clk_in,
  input wire arst_n_in,
  input wire tx_cmd_n_in,
  input wire mode_select_low_bit_in,
  input wire mode_select_high_bit_in,
  input wire bus_line_io_in,
  input wire bus_wake_level_in,
  input wire ground_loss_in,
  input wire [SLEW_W-1:0] slew_program_in,
  input wire bus_line_io_out,
  input wire bus_high_volt_out,
  input wire slew_enable_out,
  input wire [SLEW_W-1:0] slew_strength_out,
  input wire rx_data_out,
  input wire rx_data_oe_out,
  input wire load_switch_on_out,
  input wire dom_timeout_out,
  input wire awake_out
);
  localparam int TO_HI = (DOM_TIMEOUT_TICKS + 1) * TICK_CYCLES + 2;
  wire [1:0] msel = {mode_select_high_bit_in, mode_select_low_bit_in};
  wire bus_any = bus_line_io_in | bus_wake_level_in;
  reg [15:0] dom_cnt_q;
  // Length of the current dominant drive
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dom_cnt_q <= 16'h0000;
    end else begin
      dom_cnt_q <= bus_line_io_out ? dom_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  sequence held_hs; msel == 2'h1 [*6]; endsequence
  sequence held_wc; msel == 2'h2 [*6]; endsequence
  sequence held_nm; msel == 2'h3 [*6]; endsequence
  sequence gnd_ok; !ground_loss_in [*5]; endsequence
  AST_HS: assert property (held_hs |-> awake_out && !slew_enable_out)
    else $error("high speed mode outputs wrong");
  AST_WCALL: assert property (held_wc |-> bus_high_volt_out == bus_line_io_out)
    else $error("wake call drive level wrong");
  AST_NORM: assert property (held_nm |-> awake_out && !bus_high_volt_out)
    else $error("normal mode drive level wrong");
  AST_SLEW: assert property (slew_enable_out |-> slew_strength_out == $past(slew_program_in))
    else $error("slew strength wrong");
  AST_SLEW_OFF: assert property (!slew_enable_out |-> slew_strength_out == '0)
    else $error("slew strength left on without shaping");
  AST_TX_DOM: assert property ($rose(bus_line_io_out) |-> !$past(tx_cmd_n_in, 2))
    else $error("drive without low transmit command");
  AST_TX_REL: assert property ($rose(tx_cmd_n_in) |-> ##[1:4] !dom_timeout_out)
    else $error("timeout not cleared by high command");
  AST_TO_MAX: assert property (dom_cnt_q <= TO_HI)
    else $error("dominant drive outlived timeout");
  AST_GND_OPEN: assert property ($rose(ground_loss_in) |-> ##[1:4] !load_switch_on_out)
    else $error("load switch not opened");
  AST_GND_CLOSED: assert property (gnd_ok |-> load_switch_on_out)
    else $error("load switch open without ground loss");
  AST_RX_OD: assert property (!rx_data_out)
    else $error("receive output driven high");
  AST_RX_FILT: assert property ($rose(rx_data_oe_out) |-> $past(bus_any, 5))
    else $error("receive follows short disturbance");
endmodule

bind swb_ctrl swb_ctrl_chk #(.TICK_CYCLES(TICK_CYCLES),
  .DOM_TIMEOUT_TICKS(DOM_TIMEOUT_TICKS), .SLEW_W(SLEW_W)) u_chk (.*);

// File: verif/swb_ctl_model.sv
`timescale 1ns/10ps
// ------
// Controller model: transmit and mode pins
// ------
module swb_ctl_model (
  input wire clk_in,
  output wire tx_cmd_n_out,
  output wire mode_lo_out,
  output wire mode_hi_out
);
  reg tx_en = 1'b0;
  reg tx_v = 1'b1;
  reg m_en = 1'b0;
  reg [1:0] m_v = 2'h0;
  // Released pins settle at their pull levels
  assign tx_cmd_n_out = tx_en ? tx_v : 1'b1;
  assign mode_hi_out = m_en ? m_v[1] : 1'b0;
  assign mode_lo_out = m_en ? m_v[0] : 1'b0;
  task send(input reg v);
    @(posedge clk_in);
    #1;
    tx_en = 1'b1;
    tx_v = v;
  endtask
  task set_mode(input reg [1:0] m);
    @(posedge clk_in);
    #1;
    m_en = 1'b1;
    m_v = m;
  endtask
endmodule

// File: verif/swb_ctrl_bench.sv
`timescale 1ns/10ps
// ------
// Testbench
// ------
module swb_ctrl_bench;
  localparam TC = 2;
  localparam DT = 20;
  reg clk_in = 1'b0;
  reg arst_n_in = 1'b0;
  wire tx_cmd_n_in;
  wire mode_select_low_bit_in;
  wire mode_select_high_bit_in;
  reg bus_line_io_in = 1'b0;
  reg bus_wake_level_in = 1'b0;
  reg ground_loss_in = 1'b0;
  reg [3:0] slew_program_in = 4'hA;
  wire bus_line_io_out;
  wire bus_line_io_oe_out;
  wire bus_high_volt_out;
  wire slew_enable_out;
  wire [3:0] slew_strength_out;
  wire rx_data_out;
  wire rx_data_oe_out;
  wire load_switch_on_out;
  wire dom_timeout_out;
  wire awake_out;
  integer n_fail = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer i;
  swb_ctrl #(.TICK_CYCLES(TC), .DOM_TIMEOUT_TICKS(DT), .FILTER_TICKS(2)) DUT (.*);
  swb_ctl_model u_ctl (.clk_in(clk_in), .tx_cmd_n_out(tx_cmd_n_in),
    .mode_lo_out(mode_select_low_bit_in), .mode_hi_out(mode_select_high_bit_in));
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  task wt(input integer n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task chk(input string nm, input [3:0] e, input [3:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task t_modes;
    reg [1:0] m;
    for (i = 0; i < 4; i = i + 1) begin
      m = i[1:0];
      u_ctl.set_mode(m);
      slew_program_in = {m, ~m};
      u_ctl.send(1'b0);
      wt(8);
      chk("mode outputs", {m != 2'h0, m[1], m == 2'h2, m != 2'h0},
        {awake_out, slew_enable_out, bus_high_volt_out, bus_line_io_out});
      chk("slew strength", m[1] ? {m, ~m} : 4'h0, slew_strength_out);
      u_ctl.send(1'b1);
      wt(6);
      chk("released", 4'h0, {bus_line_io_out, bus_line_io_oe_out,
        bus_high_volt_out, dom_timeout_out});
    end
    $display("modes done");
  endtask
  task t_timeout;
    u_ctl.send(1'b0);
    wt(DT * TC - 10);
    chk("before trip", 4'hE, {bus_line_io_out, bus_line_io_oe_out,
      slew_enable_out, dom_timeout_out});
    wt(22);
    chk("tripped", 4'h3, {bus_line_io_out, bus_line_io_oe_out,
      slew_enable_out, dom_timeout_out});
    u_ctl.send(1'b1);
    wt(4);
    chk("cleared", 4'h2, {bus_line_io_out, bus_line_io_oe_out,
      slew_enable_out, dom_timeout_out});
    u_ctl.send(1'b0);
    wt(5);
    chk("rearmed", 4'hE, {bus_line_io_out, bus_line_io_oe_out,
      slew_enable_out, dom_timeout_out});
    u_ctl.send(1'b1);
    $display("timeout done");
  endtask
  task t_rx;
    bus_line_io_in = 1'b1;
    wt(1);
    bus_line_io_in = 1'b0;
    wt(15);
    chk("glitch", 4'h0, {2'h0, rx_data_out, rx_data_oe_out});
    bus_line_io_in = 1'b1;
    wt(15);
    chk("rx dominant", 4'h1, {2'h0, rx_data_out, rx_data_oe_out});
    bus_line_io_in = 1'b0;
    wt(15);
    chk("rx recessive", 4'h0, {2'h0, rx_data_out, rx_data_oe_out});
    u_ctl.set_mode(2'h0);
    wt(6);
    bus_line_io_in = 1'b1;
    wt(15);
    chk("rx sleep", 4'h0, {awake_out, 1'b0, rx_data_out, rx_data_oe_out});
    $display("rx done");
  endtask
  task t_wake;
    u_ctl.send(1'b0);
    bus_wake_level_in = 1'b1;
    wt(15);
    chk("bus wake", 4'h9, {awake_out, bus_line_io_out, rx_data_out, rx_data_oe_out});
    bus_wake_level_in = 1'b0;
    bus_line_io_in = 1'b0;
    wt(15);
    chk("back asleep", 4'h0, {awake_out, bus_line_io_out, rx_data_out,
      rx_data_oe_out});
    u_ctl.send(1'b1);
    $display("wake done");
  endtask
  task t_gnd;
    ground_loss_in = 1'b1;
    wt(6);
    chk("ground lost", 4'h0, {awake_out, 2'h0, load_switch_on_out});
    ground_loss_in = 1'b0;
    wt(6);
    chk("ground back", 4'h1, {awake_out, 2'h0, load_switch_on_out});
    $display("ground done");
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    arst_n_in = 1'b1;
    wt(6);
    chk("reset state", 4'h1, {awake_out, bus_line_io_out, rx_data_out,
      load_switch_on_out});
    $display("reset done");
    t_modes;
    t_timeout;
    t_rx;
    t_wake;
    t_gnd;
    print_verdict;
  end
endmodule
